// file: logic/sert_defines.svh
/*
 Register numbers, field positions, reset values and the drop-reason codes for the
 egress rate, default tag and ingress drop counter register bank.
 Assumes it is included by bare name from the package and the design modules.
*/
`ifndef SERT_DEFINES_SVH
`define SERT_DEFINES_SVH

// Register bus widths
`define SERT_ADDR_W          16
`define SERT_DATA_W          32

// Register numbers; the address port carries the register number directly
`define SERT_IDX_P1_RATE_Q23 16'h1C10
`define SERT_IDX_P2_RATE_Q01 16'h1C11
`define SERT_IDX_P2_RATE_Q23 16'h1C12
`define SERT_IDX_P0_TAG      16'h1C13
`define SERT_IDX_P1_TAG      16'h1C14
`define SERT_IDX_P2_TAG      16'h1C15
`define SERT_IDX_P0_DROPS    16'h1C16
`define SERT_IDX_P1_DROPS    16'h1C17
`define SERT_IDX_P2_DROPS    16'h1C18

// Egress rate register layout: higher queue high, lower queue low
`define SERT_RATE_W          13
`define SERT_RATE_HI_MSB     25
`define SERT_RATE_HI_LSB     13
`define SERT_RATE_LO_MSB     12
`define SERT_RATE_LO_LSB     0
`define SERT_RATE_RST        13'h0000

// Per-byte interval: (field + 1) times the step, in nanoseconds
`define SERT_INTERVAL_W      19
`define SERT_RATE_STEP_NS    19'h00014
`define SERT_INTERVAL_ONE    19'h00001

// Default tag register layout
`define SERT_PRI_W           3
`define SERT_VID_W           12
`define SERT_TAG_PRI_MSB     14
`define SERT_TAG_PRI_LSB     12
`define SERT_TAG_VID_MSB     11
`define SERT_TAG_VID_LSB     0
`define SERT_PRI_RST         3'h0
`define SERT_VID_RST         12'h000

// Drop counters
`define SERT_CNT_W           32
`define SERT_CNT_RST         32'h0000_0000
`define SERT_CNT_MAX         32'hFFFF_FFFF
`define SERT_CNT_ONE         32'h0000_0001

// Drop reasons that belong to ingress rate limiting
`define SERT_REASON_W        4
`define SERT_REASON_RED      4'h1
`define SERT_REASON_YELLOW   4'h9

// Source port encoding
`define SERT_PORT_W          2
`define SERT_NUM_PORTS       3
`define SERT_NUM_QUEUES      6

`endif

// file: logic/sert_pkg.sv
/*
 Types shared by the register bank and its drop counters.
 Assumes sert_defines.svh is on the include path.
*/
package sert_pkg;
    `include "sert_defines.svh"

    typedef logic [`SERT_RATE_W-1:0]     sert_rate_t;
    typedef logic [`SERT_INTERVAL_W-1:0] sert_interval_t;
    typedef logic [`SERT_PRI_W-1:0]      sert_pri_t;
    typedef logic [`SERT_VID_W-1:0]      sert_vid_t;
    typedef logic [`SERT_CNT_W-1:0]      sert_cnt_t;

    // Which register an address selects
    typedef enum logic [3:0] {
        SERT_SEL_NONE,
        SERT_SEL_P1_RATE_Q23,
        SERT_SEL_P2_RATE_Q01,
        SERT_SEL_P2_RATE_Q23,
        SERT_SEL_P0_TAG,
        SERT_SEL_P1_TAG,
        SERT_SEL_P2_TAG,
        SERT_SEL_P0_DROPS,
        SERT_SEL_P1_DROPS,
        SERT_SEL_P2_DROPS
    } sert_sel_t;
endpackage

// file: logic/sert_drop_counter.sv
/*
 One saturating, clear-on-read packet drop counter.
 Assumes inc_in and clr_in are synchronous one-cycle pulses from the owner.
*/
`timescale 1ns/1ps
`include "sert_defines.svh"

module sert_drop_counter (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              inc_in,
    input  wire logic              clr_in,
    output sert_pkg::sert_cnt_t    count_out
);
    import sert_pkg::*;

    sert_cnt_t count_reg;
    sert_cnt_t count_next;

    // A drop in the read cycle is kept: the reader got the old value, the new drop starts the next count
    always_comb begin
        count_next = count_reg;
        if (clr_in) begin
            count_next = inc_in ? `SERT_CNT_ONE : `SERT_CNT_RST; // R10
        end else if (inc_in && (count_reg != `SERT_CNT_MAX)) begin
            count_next = count_reg + `SERT_CNT_ONE; // R11
        end
    end

    // Counter state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= `SERT_CNT_RST; // R12
        end else begin
            count_reg <= count_next;
        end
    end

    assign count_out = count_reg;
endmodule

// file: logic/sert_regs.sv
/*
 Egress rate, default tag and ingress rate-limit drop counter register bank of a
 three-port switch buffer manager, with its register port and the outputs that the
 shaper and tagging logic consume.
 Assumes one clock, a master that never issues read and write together, and drop
 reports from the buffer manager as one-cycle pulses synchronous to clk_in.
 The address port carries the register number itself, not a byte address.
 A saturated counter loses further drops until read, but never wraps.
*/
// Implementation choice: the strobed register port.
// How it works
// R01 - Each egress rate register holds two 13-bit fields, higher queue in 25:13 and lower in 12:0, both read/write.
// R02 - A rate field N means one byte every (N + 1) times 20 ns for that queue.
// R03 - The rate is time per byte, so a larger value drains the queue more slowly.
// R04 - Each priority queue has its own rate setting, paired 0/1 and 2/3 per register; the bank holds only p1q2, p1q3 and p2q0 to p2q3.
// R05 - Every egress rate field resets to zero, the shortest per-byte interval.
// R06 - Bits 14:12 of each port's default tag register give the priority for inserted or changed tags.
// R07 - Bits 11:0 of each port's default tag register give the VLAN ID for inserted or changed tags.
// R08 - Ports 0, 1 and 2 each have a default tag register whose fields reset to zero.
// R09 - A 32-bit per-port counter counts packets dropped by ingress rate limiting (red and random yellow).
// R10 - Reading a drop counter returns its value and clears it.
// R11 - A drop counter stops at its maximum instead of wrapping.
// R12 - Drop counters reset to zero and count only drops from their own port.
// R13 - Reserved bits read zero and ignore writes, and writes leave the drop counters unchanged.
`timescale 1ns/1ps
`include "sert_defines.svh"

module sert_regs (
    input  wire logic                        clk_in,
    input  wire logic                        rst_n_in,
    // Register port
    input  wire logic [`SERT_ADDR_W-1:0]     addr_in,
    input  wire logic [`SERT_DATA_W-1:0]     wr_data_in,
    input  wire logic                        wr_en_in,
    input  wire logic                        rd_en_in,
    output logic [`SERT_DATA_W-1:0]          rd_data_out,
    // Drop reports from the buffer manager
    input  wire logic                        drop_valid_in,
    input  wire logic [`SERT_PORT_W-1:0]     drop_src_port_in,
    input  wire logic [`SERT_REASON_W-1:0]   drop_reason_in,
    // Egress shaper settings: 0 p1q2, 1 p1q3, 2 p2q0, 3 p2q1, 4 p2q2, 5 p2q3
    output sert_pkg::sert_rate_t [`SERT_NUM_QUEUES-1:0]     rate_field_out,
    output sert_pkg::sert_interval_t [`SERT_NUM_QUEUES-1:0] byte_interval_ns_out,
    // Default tag values per port
    output sert_pkg::sert_pri_t [`SERT_NUM_PORTS-1:0]       default_pri_out,
    output sert_pkg::sert_vid_t [`SERT_NUM_PORTS-1:0]       default_vid_out
);
    import sert_pkg::*;

    // Register number to selection; used by both the write and the read paths
    function automatic sert_sel_t decode_sel(input logic [`SERT_ADDR_W-1:0] addr);
        sert_sel_t sel;
        sel = SERT_SEL_NONE;
        // Anything outside the bank selects nothing
        case (addr)
            `SERT_IDX_P1_RATE_Q23: sel = SERT_SEL_P1_RATE_Q23;
            `SERT_IDX_P2_RATE_Q01: sel = SERT_SEL_P2_RATE_Q01;
            `SERT_IDX_P2_RATE_Q23: sel = SERT_SEL_P2_RATE_Q23;
            `SERT_IDX_P0_TAG:      sel = SERT_SEL_P0_TAG;
            `SERT_IDX_P1_TAG:      sel = SERT_SEL_P1_TAG;
            `SERT_IDX_P2_TAG:      sel = SERT_SEL_P2_TAG;
            `SERT_IDX_P0_DROPS:    sel = SERT_SEL_P0_DROPS;
            `SERT_IDX_P1_DROPS:    sel = SERT_SEL_P1_DROPS;
            `SERT_IDX_P2_DROPS:    sel = SERT_SEL_P2_DROPS;
            default:               sel = SERT_SEL_NONE;
        endcase
        return sel;
    endfunction

    // Per-byte interval in ns; the largest field gives 163840 ns, inside 19 bits
    function automatic sert_interval_t rate_to_interval(input sert_rate_t rate);
        sert_interval_t widened;
        // Widen first so the product keeps all its bits
        widened = {{(`SERT_INTERVAL_W-`SERT_RATE_W){1'b0}}, rate};
        return (widened + `SERT_INTERVAL_ONE) * `SERT_RATE_STEP_NS; // R02 R03
    endfunction

    // Pack a queue pair into the register image; bits 31:26 stay zero
    function automatic logic [`SERT_DATA_W-1:0] pack_rate(input sert_rate_t hi, input sert_rate_t lo);
        logic [`SERT_DATA_W-1:0] word;
        word = '0;
        word[`SERT_RATE_HI_MSB:`SERT_RATE_HI_LSB] = hi; // R01
        word[`SERT_RATE_LO_MSB:`SERT_RATE_LO_LSB] = lo; // R01
        return word;
    endfunction

    // Pack a default tag into the register image; bits 31:15 stay zero
    function automatic logic [`SERT_DATA_W-1:0] pack_tag(input sert_pri_t pri, input sert_vid_t vid);
        logic [`SERT_DATA_W-1:0] word;
        word = '0;
        word[`SERT_TAG_PRI_MSB:`SERT_TAG_PRI_LSB] = pri; // R06
        word[`SERT_TAG_VID_MSB:`SERT_TAG_VID_LSB] = vid; // R07
        return word;
    endfunction

    // Decoded access of the current cycle
    sert_sel_t                                 sel;
    logic                                      wr_hit;
    logic                                      rd_hit;

    // Shaper settings and their intervals
    sert_rate_t     [`SERT_NUM_QUEUES-1:0]     rate_reg;
    sert_rate_t     [`SERT_NUM_QUEUES-1:0]     rate_next;
    sert_interval_t [`SERT_NUM_QUEUES-1:0]     interval_reg;
    sert_interval_t [`SERT_NUM_QUEUES-1:0]     interval_next;

    // Default tag fields, one set per port
    sert_pri_t      [`SERT_NUM_PORTS-1:0]      pri_reg;
    sert_pri_t      [`SERT_NUM_PORTS-1:0]      pri_next;
    sert_vid_t      [`SERT_NUM_PORTS-1:0]      vid_reg;
    sert_vid_t      [`SERT_NUM_PORTS-1:0]      vid_next;

    // Registered read answer
    logic           [`SERT_DATA_W-1:0]         rd_data_reg;
    logic           [`SERT_DATA_W-1:0]         rd_data_next;

    // Drop counter control and values
    logic           [`SERT_NUM_PORTS-1:0]      cnt_inc;
    logic           [`SERT_NUM_PORTS-1:0]      cnt_clr;
    sert_cnt_t      [`SERT_NUM_PORTS-1:0]      cnt_value;
    logic                                      rate_limit_drop;

    // Address decode shared by reads and writes
    always_comb begin
        // One decode feeds both strobes, so they cannot disagree
        sel    = decode_sel(addr_in);
        wr_hit = wr_en_in && (sel != SERT_SEL_NONE);
        rd_hit = rd_en_in && (sel != SERT_SEL_NONE);
    end

    // Rate fields: each write replaces one queue pair; interval follows in the same edge
    always_comb begin
        rate_next = rate_reg;
        if (wr_hit) begin
            unique case (sel)
                SERT_SEL_P1_RATE_Q23: begin
                    rate_next[0] = wr_data_in[`SERT_RATE_LO_MSB:`SERT_RATE_LO_LSB]; // R01 R04
                    rate_next[1] = wr_data_in[`SERT_RATE_HI_MSB:`SERT_RATE_HI_LSB]; // R01 R04
                end

                SERT_SEL_P2_RATE_Q01: begin
                    rate_next[2] = wr_data_in[`SERT_RATE_LO_MSB:`SERT_RATE_LO_LSB]; // R01 R04
                    rate_next[3] = wr_data_in[`SERT_RATE_HI_MSB:`SERT_RATE_HI_LSB]; // R01 R04
                end

                SERT_SEL_P2_RATE_Q23: begin
                    rate_next[4] = wr_data_in[`SERT_RATE_LO_MSB:`SERT_RATE_LO_LSB]; // R01 R04
                    rate_next[5] = wr_data_in[`SERT_RATE_HI_MSB:`SERT_RATE_HI_LSB]; // R01 R04
                end

                default: begin
                    rate_next = rate_reg; // Tags and counters handled elsewhere
                end
            endcase
        end
        // Interval follows rate_next, so both flops change at one edge
        for (int q = 0; q < `SERT_NUM_QUEUES; q++) begin
            interval_next[q] = rate_to_interval(rate_next[q]); // R02
        end
    end

    // Rate state; interval is registered so the shaper sees a flop, not a multiplier
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // Zero field: one byte per 20 ns step
            for (int q = 0; q < `SERT_NUM_QUEUES; q++) begin
                rate_reg[q]     <= `SERT_RATE_RST; // R05
                interval_reg[q] <= `SERT_RATE_STEP_NS; // R05
            end
        end else begin
            rate_reg     <= rate_next;
            interval_reg <= interval_next;
        end
    end

    // Default tags: only the priority and VLAN ID bits are stored, the rest is dropped
    always_comb begin
        pri_next = pri_reg;
        vid_next = vid_reg;
        if (wr_hit) begin
            unique case (sel)
                SERT_SEL_P0_TAG: begin
                    pri_next[0] = wr_data_in[`SERT_TAG_PRI_MSB:`SERT_TAG_PRI_LSB]; // R06
                    vid_next[0] = wr_data_in[`SERT_TAG_VID_MSB:`SERT_TAG_VID_LSB]; // R07
                end

                SERT_SEL_P1_TAG: begin
                    pri_next[1] = wr_data_in[`SERT_TAG_PRI_MSB:`SERT_TAG_PRI_LSB]; // R06
                    vid_next[1] = wr_data_in[`SERT_TAG_VID_MSB:`SERT_TAG_VID_LSB]; // R07
                end

                SERT_SEL_P2_TAG: begin
                    pri_next[2] = wr_data_in[`SERT_TAG_PRI_MSB:`SERT_TAG_PRI_LSB]; // R06
                    vid_next[2] = wr_data_in[`SERT_TAG_VID_MSB:`SERT_TAG_VID_LSB]; // R07
                end

                default: begin
                    pri_next = pri_reg; // Rate and counter writes do not touch tags
                    vid_next = vid_reg;
                end
            endcase
        end
    end

    // Default tag state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // Every port starts with priority 0 and VLAN ID 0
            for (int p = 0; p < `SERT_NUM_PORTS; p++) begin
                pri_reg[p] <= `SERT_PRI_RST; // R08
                vid_reg[p] <= `SERT_VID_RST; // R08
            end
        end else begin
            pri_reg <= pri_next;
            vid_reg <= vid_next;
        end
    end

    // Only red drops and randomly chosen yellow drops count; other drop reasons are ignored
    always_comb begin
        // Reason and port must both qualify before a count moves
        rate_limit_drop = drop_valid_in &&
                          ((drop_reason_in == `SERT_REASON_RED) ||
                           (drop_reason_in == `SERT_REASON_YELLOW)); // R09

        for (int p = 0; p < `SERT_NUM_PORTS; p++) begin
            // Port code 3 matches no counter
            cnt_inc[p] = rate_limit_drop && (drop_src_port_in == p[`SERT_PORT_W-1:0]); // R12
        end

        // Clear only on a read; a write to a counter is refused silently
        cnt_clr[0] = rd_en_in && (sel == SERT_SEL_P0_DROPS); // R10 R13
        cnt_clr[1] = rd_en_in && (sel == SERT_SEL_P1_DROPS); // R10 R13
        cnt_clr[2] = rd_en_in && (sel == SERT_SEL_P2_DROPS); // R10 R13
    end

    // One saturating counter per source port
    for (genvar gp = 0; gp < `SERT_NUM_PORTS; gp++) begin : g_drop
        // Saturation and the clear/drop race live inside the counter
        sert_drop_counter u_drop_counter (
            .clk_in    (clk_in),
            .rst_n_in  (rst_n_in),
            .inc_in    (cnt_inc[gp]),
            .clr_in    (cnt_clr[gp]),
            .count_out (cnt_value[gp])
        );
    end

    // Read mux; the counter value is taken before its clear lands, so the reader sees it once
    always_comb begin
        rd_data_next = '0;
        if (rd_hit) begin
            unique case (sel)
                SERT_SEL_P1_RATE_Q23: begin
                    rd_data_next = pack_rate(rate_reg[1], rate_reg[0]); // R01 R13
                end
                SERT_SEL_P2_RATE_Q01: begin
                    rd_data_next = pack_rate(rate_reg[3], rate_reg[2]); // R01 R13
                end
                SERT_SEL_P2_RATE_Q23: begin
                    rd_data_next = pack_rate(rate_reg[5], rate_reg[4]); // R01 R13
                end
                // Reserved bits come back zero from the pack functions
                SERT_SEL_P0_TAG: begin
                    rd_data_next = pack_tag(pri_reg[0], vid_reg[0]); // R13
                end
                SERT_SEL_P1_TAG: begin
                    rd_data_next = pack_tag(pri_reg[1], vid_reg[1]); // R13
                end
                SERT_SEL_P2_TAG: begin
                    rd_data_next = pack_tag(pri_reg[2], vid_reg[2]); // R13
                end
                // The count before this edge's clear
                SERT_SEL_P0_DROPS: begin
                    rd_data_next = cnt_value[0]; // R10
                end
                SERT_SEL_P1_DROPS: begin
                    rd_data_next = cnt_value[1]; // R10
                end
                SERT_SEL_P2_DROPS: begin
                    rd_data_next = cnt_value[2]; // R10
                end
                default: begin
                    rd_data_next = '0;
                end
            endcase
        end
    end

    // Read data stands for exactly the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // All outputs come straight from flops
    assign rd_data_out          = rd_data_reg;
    assign rate_field_out       = rate_reg;
    assign byte_interval_ns_out = interval_reg;
    assign default_pri_out      = pri_reg;
    assign default_vid_out      = vid_reg;
endmodule

// file: sim/sert_regs_sva.sv
/*
 Port-level assertions for the egress rate, default tag and drop counter register bank.
 Assumes it is bound into sert_regs; one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "sert_defines.svh"

module sert_regs_sva
    import sert_pkg::*;
(
    input  wire logic                                          clk_in,
    input  wire logic                                          rst_n_in,
    input  wire logic [`SERT_ADDR_W-1:0]                       addr_in,
    input  wire logic [`SERT_DATA_W-1:0]                       wr_data_in,
    input  wire logic                                          wr_en_in,
    input  wire logic                                          rd_en_in,
    input  wire logic [`SERT_DATA_W-1:0]                       rd_data_out,
    input  wire logic                                          drop_valid_in,
    input  wire sert_pkg::sert_rate_t [`SERT_NUM_QUEUES-1:0]     rate_field_out,
    input  wire sert_pkg::sert_interval_t [`SERT_NUM_QUEUES-1:0] byte_interval_ns_out,
    input  wire sert_pkg::sert_pri_t [`SERT_NUM_PORTS-1:0]       default_pri_out,
    input  wire sert_pkg::sert_vid_t [`SERT_NUM_PORTS-1:0]       default_vid_out
);
    import sert_pkg::*;
    logic [`SERT_DATA_W-1:0] wd_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Last cycle's write data, so field checks need no slice of a past value
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) wd_q <= '0;
        else wd_q <= wr_data_in;
    end

    // Read data appear only in the cycle after a read strobe
    a_rdata_idle: assert property (!rd_en_in |=> rd_data_out == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    a_reset_values: assert property ($rose(rst_n_in) |-> rate_field_out == '0 && default_pri_out == '0
        && default_vid_out == '0) else $error("outputs not at reset values after reset");
    a_cfg_hold: assert property (!wr_en_in |=> $stable(rate_field_out) && $stable(default_pri_out)
        && $stable(default_vid_out)) else $error("configuration changed without a write");
    a_unmapped_read: assert property (rd_en_in && (addr_in < 16'h1C10 || addr_in > 16'h1C18)
        |=> rd_data_out == 32'h0000_0000) else $error("unmapped read returned nonzero");
    // Two reads of one counter back to back with no drop between: the second sees zero
    a_read_clear: assert property ((rd_en_in && addr_in >= 16'h1C16 && addr_in <= 16'h1C18 && !drop_valid_in)
        ##1 (rd_en_in && $stable(addr_in)) |=> rd_data_out == 32'h0000_0000) else $error("counter not cleared by read");

    for (genvar q = 0; q < `SERT_NUM_QUEUES; q++) begin : g_q
        a_interval_calc: assert property (byte_interval_ns_out[q] == (19'(rate_field_out[q]) + 19'h1) * 19'h14)
            else $error("byte interval does not match rate field");
    end
    for (genvar r = 0; r < 3; r++) begin : g_rate
        a_rate_write: assert property (wr_en_in && addr_in == `SERT_IDX_P1_RATE_Q23 + 16'(r)
            |=> {rate_field_out[2*r+1], rate_field_out[2*r]} == wd_q[25:0]) else $error("rate write not taken");
        a_rate_read: assert property (rd_en_in && addr_in == `SERT_IDX_P1_RATE_Q23 + 16'(r)
            |=> rd_data_out == {6'h00, rate_field_out[2*r+1], rate_field_out[2*r]}) else $error("rate read wrong");
    end
    for (genvar p = 0; p < `SERT_NUM_PORTS; p++) begin : g_tag
        a_tag_write: assert property (wr_en_in && addr_in == `SERT_IDX_P0_TAG + 16'(p)
            |=> {default_pri_out[p], default_vid_out[p]} == wd_q[14:0]) else $error("tag write not taken");
        a_tag_read: assert property (rd_en_in && addr_in == `SERT_IDX_P0_TAG + 16'(p)
            |=> rd_data_out == {17'h0_0000, default_pri_out[p], default_vid_out[p]}) else $error("tag read wrong");
    end
endmodule

bind sert_regs sert_regs_sva u_sert_regs_sva (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .drop_valid_in(drop_valid_in),
    .rate_field_out(rate_field_out), .byte_interval_ns_out(byte_interval_ns_out),
    .default_pri_out(default_pri_out), .default_vid_out(default_vid_out)
);

// file: sim/sert_regs_tb.sv
/*
 Self-checking bench for the register bank: register port tasks and drop report pulses.
 Assumes the checker is bound in beside it. Saturation at the counter maximum is out of
 reach in simulation time, so only wrap-free counting is exercised.
*/
`timescale 1ns/1ps
`include "sert_defines.svh"

module sert_regs_tb;
    import sert_pkg::*;
    logic                            clk_in, rst_n_in, wr_en_in, rd_en_in, drop_valid_in;
    logic [15:0]                     addr_in;
    logic [31:0]                     wr_data_in, rd_data_out;
    logic [1:0]                      drop_src_port_in;
    logic [3:0]                      drop_reason_in;
    sert_rate_t [5:0]                rate_field_out;
    sert_interval_t [5:0]            byte_interval_ns_out;
    sert_pri_t [2:0]                 default_pri_out;
    sert_vid_t [2:0]                 default_vid_out;
    logic [12:0]                     exp_rate [6];
    logic [2:0]                      exp_pri [3];
    logic [11:0]                     exp_vid [3];
    int                              num_errors, comparisons;

    sert_regs u_sert_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .drop_valid_in(drop_valid_in),
        .drop_src_port_in(drop_src_port_in), .drop_reason_in(drop_reason_in), .rate_field_out(rate_field_out),
        .byte_interval_ns_out(byte_interval_ns_out), .default_pri_out(default_pri_out),
        .default_vid_out(default_vid_out));

    // 25 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe; outputs settle just after the taking edge
    task wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a; wr_data_in <= d; wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        addr_in <= a; rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1;
        check(rd_data_out, exp);
    endtask

    // Two reads back to back; a red drop on port dp rides the first read (3 means none)
    task rd2(input logic [15:0] a, input logic [1:0] dp, input logic [31:0] e1, input logic [31:0] e2);
        @(posedge clk_in);
        addr_in <= a; rd_en_in <= 1'b1;
        drop_valid_in <= (dp != 2'd3); drop_src_port_in <= dp; drop_reason_in <= `SERT_REASON_RED;
        @(posedge clk_in);
        drop_valid_in <= 1'b0;
        #1;
        check(rd_data_out, e1);
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1;
        check(rd_data_out, e2);
    endtask

    // n drop reports back to back from one port with one reason
    task drop(input logic [1:0] p, input logic [3:0] r, input int n);
        @(posedge clk_in);
        drop_valid_in <= 1'b1; drop_src_port_in <= p; drop_reason_in <= r;
        repeat (n) @(posedge clk_in);
        drop_valid_in <= 1'b0;
    endtask

    // All shaper and tag outputs against the expected tables
    task chk_cfg();
        for (int q = 0; q < 6; q++) begin
            check(rate_field_out[q], exp_rate[q]);
            check(byte_interval_ns_out[q], (19'(exp_rate[q]) + 19'h1) * 19'h14);
        end
        for (int p = 0; p < 3; p++) begin
            check(default_pri_out[p], exp_pri[p]);
            check(default_vid_out[p], exp_vid[p]);
        end
    endtask

    // Watchdog sized well above the roughly 150 cycles the tests need
    initial begin
        repeat (4000) @(posedge clk_in);
        num_errors++;
        give_verdict();
    end

    initial begin
        {rst_n_in, wr_en_in, rd_en_in, drop_valid_in} = 4'h0;
        {addr_in, wr_data_in, drop_src_port_in, drop_reason_in} = '0;
        exp_rate = '{default: '0}; exp_pri = '{default: '0}; exp_vid = '{default: '0};
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk_cfg();
        for (int i = 0; i < 9; i++) rd(16'h1C10 + 16'(i), 32'h0000_0000);
        // All ones shows that reserved bits read back as zero
        for (int i = 0; i < 3; i++) begin
            wr(16'h1C10 + 16'(i), 32'hFFFF_FFFF);
            rd(16'h1C10 + 16'(i), 32'h03FF_FFFF);
            wr(16'h1C13 + 16'(i), 32'hFFFF_FFFF);
            rd(16'h1C13 + 16'(i), 32'h0000_7FFF);
        end
        for (int i = 0; i < 3; i++) begin
            exp_rate[2*i] = 13'(i * 200 + 7); exp_rate[2*i+1] = 13'h1FF0 + 13'(i);
            exp_pri[i] = 3'(i + 5); exp_vid[i] = 12'hA50 + 12'(i);
            wr(16'h1C10 + 16'(i), {6'h15, exp_rate[2*i+1], exp_rate[2*i]});
            wr(16'h1C13 + 16'(i), {17'h1ABCD, exp_pri[i], exp_vid[i]});
        end
        chk_cfg();
        // Unmapped places take nothing and read zero
        wr(16'h1C19, 32'hFFFF_FFFF);
        wr(16'h1C0F, 32'h0000_0000);
        rd(16'h1C19, 32'h0000_0000);
        rd(16'h0000, 32'h0000_0000);
        chk_cfg();
        // Every reason code on port 1: only red and random yellow count
        for (int r = 0; r < 16; r++) drop(2'd1, 4'(r), 1);
        drop(2'd3, `SERT_REASON_RED, 4);
        drop(2'd2, `SERT_REASON_YELLOW, 3);
        drop(2'd0, 4'h0, 2);
        wr(16'h1C18, 32'h0000_0005);
        rd(16'h1C16, 32'h0000_0000);
        rd(16'h1C17, 32'h0000_0002);
        rd2(16'h1C18, 2'd3, 32'h0000_0003, 32'h0000_0000);
        rd(16'h1C17, 32'h0000_0000);
        // A drop in the read cycle survives the clear
        drop(2'd0, `SERT_REASON_RED, 3);
        rd2(16'h1C16, 2'd0, 32'h0000_0003, 32'h0000_0001);
        rd(16'h1C16, 32'h0000_0000);
        // Reset in mid-run returns everything to zero
        drop(2'd2, `SERT_REASON_RED, 2);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        exp_rate = '{default: '0}; exp_pri = '{default: '0}; exp_vid = '{default: '0};
        chk_cfg();
        rd(16'h1C18, 32'h0000_0000);
        give_verdict();
    end
endmodule
